// >>> hw/esbm_serial_master.sv
// Purpose: Two-wire serial-bus master with byte-wide configuration registers.
// Assumes: Register access on ref_clk_in; the wire engine runs on link_clk_in.
// Notes: Pins are open drain; an enable high pulls the wire low.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - SCL toggles near 100 kHz, never faster.
// - Idle bus: SCL released, no edges.
// - Up to 100 kbit/s, seven-bit addressing.
// - EEPROM present when SCL reads high.
// - Start: SDA falls while SCL high.
// - Stop: SDA rises while SCL high.
// - SDA changes only while SCL low.
// - Bytes MSB first, ninth bit acknowledges.
// - Byte write address carries direction 0.
// - Missing acknowledge sets error status bit.
// - Word address from index register follows.
// - Write data byte, acknowledge, then stop.
// - Byte read address carries direction 1.
// - Slave drives read data; master clocks, acknowledges all but the last byte.
// - Multi-byte reads only from automatic load.
// - Data register holds sent or received byte.
// - Index supplies word address; quick ignores it.
// - Writing target address launches the transfer.
// - Status: read-valid, busy, error, protocol select.
// - Automatic load addresses EEPROM 1010000b.
// - After reset, detected EEPROM is read.
module esbm_serial_master (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic link_clk_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_wdata_in,
  output logic [7:0] cfg_rdata_out,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic [7:0] load_byte_out,
  output logic [7:0] load_offset_out,
  output logic load_strobe_out
);
  import esbm_pkg::*;

  // Register-clock domain.
  logic scl_ref;
  logic [5:0] det_cnt_q;
  logic rom_found_q;
  logic det_fire;
  logic auto_go;
  logic launch_sw;
  logic launch;
  logic done_evt;
  logic byte_evt;
  logic [7:0] data_q;
  logic [7:0] index_q;
  logic [7:0] taddr_q;
  logic quick_q;
  logic err_q;
  logic busy_q;
  logic rdv_q;
  logic [6:0] cmd_addr_q;
  logic cmd_rw_q;
  logic cmd_quick_q;
  logic [7:0] cmd_index_q;
  logic [7:0] cmd_wdata_q;
  logic [2:0] cmd_count_q;
  logic cmd_auto_q;
  logic [7:0] load_ofs_q;
  // Link-clock domain.
  logic lrst_n;
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic cmd_go;
  esbm_step_t step_q;
  esbm_step_t step_nx;
  logic [1:0] phase_q;
  logic [5:0] qcnt_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] rx_byte_q;
  logic [2:0] left_q;
  logic lerr_q;
  logic done_q;
  logic byte_q;
  logic scl_low_q;
  logic sda_low_q;
  logic scl_low_d;
  logic sda_low_d;
  logic [6:0] low_cnt_q;
  logic tick;
  logic step_end;
  logic [7:0] load_val;

  esbm_sync2 #(.WIDTH(1)) u_scl_ref (
    .clk_in(ref_clk_in),
    .d_in(scl_in),
    .q_out(scl_ref)
  );

  esbm_sync2 #(.WIDTH(1)) u_lrst (
    .clk_in(link_clk_in),
    .d_in(reset_n_in),
    .q_out(lrst_n)
  );

  esbm_sync2 #(.WIDTH(2)) u_pins (
    .clk_in(link_clk_in),
    .d_in({scl_in, sda_in}),
    .q_out(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  esbm_evt_xfer u_cmd_xfer (
    .src_clk_in(ref_clk_in),
    .src_rst_n_in(reset_n_in),
    .src_pulse_in(launch),
    .dst_clk_in(link_clk_in),
    .dst_rst_n_in(lrst_n),
    .dst_pulse_out(cmd_go)
  );

  esbm_evt_xfer u_done_xfer (
    .src_clk_in(link_clk_in),
    .src_rst_n_in(lrst_n),
    .src_pulse_in(done_q),
    .dst_clk_in(ref_clk_in),
    .dst_rst_n_in(reset_n_in),
    .dst_pulse_out(done_evt)
  );

  esbm_evt_xfer u_byte_xfer (
    .src_clk_in(link_clk_in),
    .src_rst_n_in(lrst_n),
    .src_pulse_in(byte_q),
    .dst_clk_in(ref_clk_in),
    .dst_rst_n_in(reset_n_in),
    .dst_pulse_out(byte_evt)
  );

  // The wire is sampled only after the link side has left reset, so the launch is never lost.
  assign det_fire = (det_cnt_q == DET_FIRE);
  assign auto_go = det_fire && scl_ref;
  assign launch_sw = cfg_wr_in && (cfg_addr_in == OFS_TADDR) && !busy_q && !auto_go;
  assign launch = auto_go || launch_sw;

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      det_cnt_q <= 6'h00;
      rom_found_q <= 1'b0;
    end else if (det_cnt_q != DET_STOP) begin
      det_cnt_q <= det_cnt_q + 6'h01;
      if (det_fire) begin
        rom_found_q <= scl_ref;
      end
    end
  end

  // Command fields stay frozen while busy except at the automatic load, which ignores busy; the link side reads them after the event.
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      cmd_addr_q <= 7'h00;
      cmd_rw_q <= 1'b0;
      cmd_quick_q <= 1'b0;
      cmd_index_q <= BYTE_RST;
      cmd_wdata_q <= BYTE_RST;
      cmd_count_q <= SW_BYTES;
      cmd_auto_q <= 1'b0;
    end else if (auto_go) begin
      cmd_addr_q <= ROM_ADDR;
      cmd_rw_q <= 1'b1;
      cmd_quick_q <= 1'b0;
      cmd_index_q <= LOAD_FIRST_INDEX;
      cmd_count_q <= LOAD_BYTES;
      cmd_auto_q <= 1'b1;
    end else if (launch_sw) begin
      cmd_addr_q <= cfg_wdata_in[7:1];
      cmd_rw_q <= cfg_wdata_in[0];
      cmd_quick_q <= quick_q;
      cmd_index_q <= index_q;
      cmd_wdata_q <= data_q;
      cmd_count_q <= SW_BYTES;
      cmd_auto_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      taddr_q <= BYTE_RST;
      index_q <= BYTE_RST;
      quick_q <= 1'b0;
    end else if (cfg_wr_in) begin
      if (launch_sw) begin
        taddr_q <= cfg_wdata_in;
      end
      if (cfg_addr_in == OFS_INDEX) begin
        index_q <= cfg_wdata_in;
      end
      if (cfg_addr_in == OFS_CTRL) begin
        quick_q <= cfg_wdata_in[CTL_QUICK];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      data_q <= BYTE_RST;
    end else if (done_evt && busy_q && !lerr_q && cmd_rw_q && !cmd_quick_q && !cmd_auto_q) begin
      data_q <= rx_byte_q;
    end else if (cfg_wr_in && (cfg_addr_in == OFS_DATA)) begin
      data_q <= cfg_wdata_in;
    end
  end

  // Status flags; a hardware set in the same cycle as a software clear wins.
  // Events count only while busy: a reset reaches the link side late, so a stale toggle can echo.
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      busy_q <= 1'b0;
      err_q <= 1'b0;
      rdv_q <= 1'b0;
    end else begin
      if (launch) begin
        busy_q <= 1'b1;
        rdv_q <= 1'b0;
      end else if (done_evt && busy_q) begin
        busy_q <= 1'b0;
        rdv_q <= !lerr_q && cmd_rw_q && !cmd_quick_q && !cmd_auto_q;
      end
      if (done_evt && busy_q && lerr_q) begin
        err_q <= 1'b1;
      end else if (cfg_wr_in && (cfg_addr_in == OFS_CTRL) && cfg_wdata_in[CTL_ERR]) begin
        err_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      cfg_rdata_out <= BYTE_RST;
    end else if (cfg_rd_in) begin
      unique case (cfg_addr_in)
        OFS_DATA: cfg_rdata_out <= data_q;
        OFS_INDEX: cfg_rdata_out <= index_q;
        OFS_TADDR: cfg_rdata_out <= taddr_q;
        OFS_CTRL: cfg_rdata_out <= {3'h0, rom_found_q, rdv_q, busy_q, err_q, quick_q};
        default: cfg_rdata_out <= BYTE_RST;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      load_byte_out <= BYTE_RST;
      load_offset_out <= BYTE_RST;
      load_ofs_q <= LOAD_FIRST_INDEX;
      load_strobe_out <= 1'b0;
    end else begin
      load_strobe_out <= byte_evt && busy_q && cmd_auto_q;
      if (byte_evt && busy_q && cmd_auto_q) begin
        load_byte_out <= rx_byte_q;
        load_offset_out <= load_ofs_q;
        load_ofs_q <= load_ofs_q + 8'h01;
      end
    end
  end

  // Link engine: each bit slot is four quarters of one SCL period; byte steps take nine slots.
  assign tick = (qcnt_q == Q_LAST);
  assign step_end = tick && (phase_q == 2'h3);

  always_comb begin
    step_nx = ST_IDLE;
    unique case (step_q)
      ST_IDLE: step_nx = ST_IDLE;
      ST_START: step_nx = ST_ADDR;
      ST_ADDR: step_nx = (sda_s || cmd_quick_q) ? ST_STOP : ST_INDEX;
      ST_INDEX: step_nx = sda_s ? ST_STOP : (cmd_rw_q ? ST_RSTART : ST_WDATA);
      ST_RSTART: step_nx = ST_RADDR;
      ST_RADDR: step_nx = sda_s ? ST_STOP : ST_RDATA;
      ST_WDATA: step_nx = ST_STOP;
      ST_RDATA: step_nx = (left_q == 3'h1) ? ST_STOP : ST_RDATA;
      ST_STOP: step_nx = ST_IDLE;
    endcase
  end

  always_comb begin
    load_val = BYTE_RST;
    unique case (step_nx)
      ST_ADDR: load_val = {cmd_addr_q, cmd_quick_q & cmd_rw_q};
      ST_INDEX: load_val = cmd_index_q;
      ST_RADDR: load_val = {cmd_addr_q, 1'b1};
      ST_WDATA: load_val = cmd_wdata_q;
      default: load_val = BYTE_RST;
    endcase
  end

  always_ff @(posedge link_clk_in) begin
    if (!lrst_n) begin
      step_q <= ST_IDLE;
      phase_q <= 2'h0;
      qcnt_q <= 6'h00;
      bit_q <= 4'h0;
    end else if (step_q == ST_IDLE) begin
      phase_q <= 2'h0;
      qcnt_q <= 6'h00;
      bit_q <= 4'h0;
      if (cmd_go) begin
        step_q <= ST_START;
      end
    end else if (tick) begin
      qcnt_q <= 6'h00;
      phase_q <= phase_q + 2'h1;
      if (phase_q == 2'h3) begin
        if (step_is_byte(step_q) && (bit_q != ACK_BIT)) begin
          bit_q <= bit_q + 4'h1;
        end else begin
          bit_q <= 4'h0;
          step_q <= step_nx;
        end
      end
    end else begin
      qcnt_q <= qcnt_q + 6'h01;
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (!lrst_n) begin
      shift_q <= BYTE_RST;
      rx_byte_q <= BYTE_RST;
      left_q <= 3'h0;
      lerr_q <= 1'b0;
      done_q <= 1'b0;
      byte_q <= 1'b0;
    end else begin
      done_q <= step_end && (step_q == ST_STOP);
      byte_q <= step_end && (step_q == ST_RDATA) && (bit_q == ACK_BIT);
      if (cmd_go && (step_q == ST_IDLE)) begin
        left_q <= cmd_count_q;
        lerr_q <= 1'b0;
      end
      if (step_end && step_is_byte(step_q) && (bit_q != ACK_BIT)) begin
        shift_q <= {shift_q[6:0], sda_s};
      end else if (step_end) begin
        shift_q <= load_val;
      end
      if (step_end && step_is_tx(step_q) && (bit_q == ACK_BIT) && sda_s) begin
        lerr_q <= 1'b1;
      end
      if (step_end && (step_q == ST_RDATA) && (bit_q == ACK_BIT)) begin
        rx_byte_q <= shift_q;
        left_q <= left_q - 3'h1;
      end
    end
  end

  // SDA holds through quarter 0 so it never moves on the same edge that SCL falls.
  always_comb begin
    scl_low_d = (phase_q < 2'h2);
    sda_low_d = sda_low_q;
    unique case (step_q)
      ST_IDLE: begin
        scl_low_d = 1'b0;
        sda_low_d = 1'b0;
      end
      ST_START: begin
        scl_low_d = 1'b0;
        sda_low_d = (phase_q >= 2'h2);
      end
      ST_RSTART: begin
        if (phase_q != 2'h0) begin
          sda_low_d = (phase_q == 2'h3);
        end
      end
      ST_STOP: begin
        if (phase_q != 2'h0) begin
          sda_low_d = (phase_q != 2'h3);
        end
      end
      default: begin
        if (phase_q != 2'h0) begin
          if (bit_q != ACK_BIT) begin
            sda_low_d = step_is_tx(step_q) && !shift_q[7];
          end else begin
            sda_low_d = (step_q == ST_RDATA) && (left_q != 3'h1);
          end
        end
      end
    endcase
  end

  always_ff @(posedge link_clk_in) begin
    if (!lrst_n) begin
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      low_cnt_q <= 7'h00;
    end else begin
      scl_low_q <= scl_low_d;
      sda_low_q <= sda_low_d;
      low_cnt_q <= scl_low_q ? low_cnt_q + 7'h01 : 7'h00;
    end
  end

  assign scl_oe_out = scl_low_q;
  assign sda_oe_out = sda_low_q;

  // The pad level when driving is always low; these flops never change.
  always_ff @(posedge link_clk_in) begin
    scl_out <= 1'b0;
    sda_out <= 1'b0;
  end

  a_scl_low_len: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    $fell(scl_low_q) |-> (low_cnt_q == LOW_CYC))
    else $error("SCL low phase has the wrong length");

  a_idle_scl_free: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    (step_q == ST_IDLE) && ($past(step_q) == ST_IDLE) |-> !scl_oe_out && !sda_oe_out)
    else $error("Bus driven while idle");

  a_start_shape: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    $rose(sda_low_q) && !scl_low_q && !$past(scl_low_q) |->
      (step_q == ST_START) || (step_q == ST_RSTART))
    else $error("SDA fell under high SCL outside a start");

  a_stop_shape: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    $fell(sda_low_q) && !scl_low_q && !$past(scl_low_q) |-> (step_q == ST_STOP))
    else $error("SDA rose under high SCL outside a stop");

  a_sda_stable_hi: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    !scl_low_q && !$past(scl_low_q) && step_is_byte(step_q) && step_is_byte($past(step_q))
      |-> $stable(sda_low_q))
    else $error("SDA moved while SCL high in a byte");

  a_msb_first: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    step_is_tx(step_q) && (phase_q == 2'h1) && (bit_q != ACK_BIT)
      |=> sda_low_q == !$past(shift_q[7]))
    else $error("Transmitted bit is not the shift register MSB");

  a_write_dir: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    (step_q == ST_ADDR) && (bit_q == 4'h0) && !cmd_quick_q |-> !shift_q[0])
    else $error("Write address byte lacks direction 0");

  a_read_dir: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    (step_q == ST_RADDR) && (bit_q == 4'h0) |-> shift_q[0])
    else $error("Read address byte lacks direction 1");

  a_nack_error: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    step_end && step_is_tx(step_q) && (bit_q == ACK_BIT) && sda_s |=> lerr_q ##[1:200] done_q)
    else $error("Missing acknowledge not recorded or not stopped");

  a_launch_busy: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    launch_sw |=> busy_q && !rdv_q && (taddr_q == $past(cfg_wdata_in)))
    else $error("Launch did not raise busy");

  a_busy_hold: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    busy_q && !done_evt |=> busy_q)
    else $error("Busy dropped before the stop completed");

  a_rdv_after_ok: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    $rose(rdv_q) |-> $past(done_evt) && !lerr_q && cmd_rw_q && !cmd_quick_q && !cmd_auto_q)
    else $error("Read valid set without a clean completion");

  a_load_rom_addr: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    busy_q && cmd_auto_q |-> (cmd_addr_q == ROM_ADDR) && cmd_rw_q)
    else $error("Automatic load not aimed at the EEPROM");
endmodule // esbm_serial_master
`default_nettype wire

// >>> hw/esbm_pkg.sv
// Purpose: Shared constants and types for the two-wire serial-bus master.
// Assumes: Byte-wide configuration registers, 50 MHz register clock, 12.5 MHz link clock.
// Notes: Timing counts are derived from the times; nothing here is a process.
package esbm_pkg;
  localparam logic [7:0] OFS_DATA = 8'hb0;
  localparam logic [7:0] OFS_INDEX = 8'hb1;
  localparam logic [7:0] OFS_TADDR = 8'hb2;
  localparam logic [7:0] OFS_CTRL = 8'hb3;
  localparam int CTL_QUICK = 0;
  localparam int CTL_ERR = 1;
  localparam int CTL_BUSY = 2;
  localparam int CTL_RDV = 3;
  localparam int CTL_ROM = 4;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [6:0] ROM_ADDR = 7'h50;
  localparam logic [7:0] LOAD_FIRST_INDEX = 8'h00;
  localparam logic [2:0] LOAD_BYTES = 3'h4;
  localparam logic [2:0] SW_BYTES = 3'h1;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam int SCL_FREQ_KHZ = 100;
  localparam int SCL_PERIOD_NS = 1000000 / SCL_FREQ_KHZ;
  localparam int LINK_PERIOD_NS = 80;
  localparam int QUARTER_CYC = (SCL_PERIOD_NS / 4 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam logic [5:0] Q_LAST = 6'(QUARTER_CYC - 1);
  localparam logic [6:0] LOW_CYC = 7'(2 * QUARTER_CYC);
  localparam int REF_PERIOD_NS = 20;
  localparam int DETECT_NS = 1000;
  localparam int DETECT_CYC = (DETECT_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam logic [5:0] DET_FIRE = 6'(DETECT_CYC - 1);
  localparam logic [5:0] DET_STOP = 6'(DETECT_CYC);

  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_ADDR, ST_INDEX, ST_RSTART, ST_RADDR, ST_WDATA, ST_RDATA, ST_STOP
  } esbm_step_t;

  function automatic logic step_is_tx(input esbm_step_t s);
    return (s == ST_ADDR) || (s == ST_INDEX) || (s == ST_RADDR) || (s == ST_WDATA);
  endfunction

  function automatic logic step_is_byte(input esbm_step_t s);
    return step_is_tx(s) || (s == ST_RDATA);
  endfunction
endpackage

// >>> hw/esbm_sync2.sv
// Purpose: Two-flop synchroniser for levels entering a clock domain.
// Assumes: Each bit is an independent level.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none
module esbm_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_in) begin
    meta_q <= d_in;
    q_out <= meta_q;
  end
endmodule // esbm_sync2
`default_nettype wire

// >>> hw/esbm_evt_xfer.sv
// Purpose: Carries a one-cycle event from one clock domain to another.
// Assumes: Events are spaced far wider than three destination clocks.
// Notes: Toggle crossing; data that rides with the event must be held by the sender.
`timescale 1ns/10ps
`default_nettype none
module esbm_evt_xfer (
  input wire logic src_clk_in,
  input wire logic src_rst_n_in,
  input wire logic src_pulse_in,
  input wire logic dst_clk_in,
  input wire logic dst_rst_n_in,
  output logic dst_pulse_out
);
  logic tog_q;
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge src_clk_in) begin
    if (!src_rst_n_in) begin
      tog_q <= 1'b0;
    end else if (src_pulse_in) begin
      tog_q <= ~tog_q;
    end
  end

  always_ff @(posedge dst_clk_in) begin
    if (!dst_rst_n_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= tog_q;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign dst_pulse_out = sync_q ^ last_q;
endmodule // esbm_evt_xfer
`default_nettype wire

// >>> sim/esbm_slave_model.sv
// Purpose: Behavioural two-wire slave memory that stands on the far side of the master.
// Assumes: The bench resolves the open-drain wires with pull-ups; a pull high drives SDA low.
// Notes: It acknowledges only its own address, so any other address exercises the nack path.
`timescale 1ns/10ps
`default_nettype none
module esbm_slave_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_pull_out
);
  logic [7:0] mem [0:255];
  logic [7:0] sh_q = 8'h00;
  logic [7:0] ptr_q = 8'h00;
  logic [7:0] cur_q = 8'h00;
  logic [3:0] cnt_q = 4'h0;
  logic [1:0] phase_q = 2'h0;
  logic act_q = 1'b0;
  logic tx_q = 1'b0;
  logic go_q = 1'b0;

  initial sda_pull_out = 1'b0;

  always @(negedge sda_in) begin
    if (scl_in === 1'b1) begin
      act_q = 1'b1;
      tx_q = 1'b0;
      cnt_q = 4'h0;
      phase_q = 2'h0;
      sda_pull_out = 1'b0;
    end
  end

  always @(posedge sda_in) begin
    if (scl_in === 1'b1) begin
      act_q = 1'b0;
      tx_q = 1'b0;
    end
  end

  // A master nack on the ack clock ends the read stream, as the last byte needs.
  always @(posedge scl_in) begin
    if (act_q) begin
      if (cnt_q < 4'h8) sh_q = {sh_q[6:0], sda_in};
      else if (tx_q && sda_in !== 1'b0) tx_q = 1'b0;
      else if (tx_q) begin
        ptr_q = ptr_q + 8'h01;
        cur_q = mem[ptr_q];
      end
      cnt_q = cnt_q + 4'h1;
    end
  end

  always @(negedge scl_in) begin
    if (act_q) begin
      if (cnt_q == 4'h8) begin
        sda_pull_out = 1'b0;
        if (!tx_q) begin
          if (phase_q == 2'h0) begin
            act_q = (sh_q[7:1] == DEV_ADDR);
            go_q = sh_q[0];
          end else if (phase_q == 2'h1) ptr_q = sh_q;
          else begin
            mem[ptr_q] = sh_q;
            ptr_q = ptr_q + 8'h01;
          end
          sda_pull_out = act_q;
          phase_q = (phase_q == 2'h2) ? 2'h2 : phase_q + 2'h1;
        end
      end else if (cnt_q == 4'h9) begin
        cnt_q = 4'h0;
        if (go_q) begin
          tx_q = 1'b1;
          go_q = 1'b0;
          cur_q = mem[ptr_q];
        end
        sda_pull_out = tx_q & ~cur_q[7];
      end else if (tx_q) sda_pull_out = ~cur_q[3'(4'h7 - cnt_q)];
    end
  end
endmodule // esbm_slave_model
`default_nettype wire

// >>> sim/eeprom_serial_bus_master_tb_top.sv
// Purpose: Self-checking bench for the serial-bus master with a slave memory model.
// Assumes: SCL pulled up, so the automatic load runs after reset, unless the bench holds SCL low.
// Notes: Register reads note their expectation in a queue; a watcher compares them.
`timescale 1ns/10ps
`default_nettype none
module eeprom_serial_bus_master_tb_top;
  import esbm_pkg::*;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic rd_seen = 1'b0;
  logic scl_hold = 1'b0;
  logic [7:0] cfg_rdata, load_byte, load_offset, v, d, ix;
  logic load_strobe, scl_oe, sda_oe, slv_pull, scl_o, sda_o;
  logic [15:0] rq[$];
  logic [15:0] lq[$];
  logic [15:0] e_r, e_l;
  wire logic scl_w;
  wire logic sda_w;
  int miscompares = 0;
  int checked = 0;
  integer seed = 32'hab1d;
  realtime last_rise = 0;

  // Pull-ups: a released or unknown enable reads as high.
  assign scl_w = scl_hold ? 1'b0 : ((scl_oe === 1'b1) ? scl_o : 1'b1);
  assign sda_w = ((sda_oe === 1'b1) ? sda_o : 1'b1) & ((slv_pull === 1'b1) ? 1'b0 : 1'b1);

  initial forever #10 ref_clk = ~ref_clk;
  initial begin
    #13;
    forever #40 link_clk = ~link_clk;
  end

  esbm_serial_master u_dut (
    .ref_clk_in(ref_clk), .reset_n_in(reset_n), .link_clk_in(link_clk),
    .cfg_addr_in(cfg_addr), .cfg_wr_in(cfg_wr), .cfg_rd_in(cfg_rd),
    .cfg_wdata_in(cfg_wdata), .cfg_rdata_out(cfg_rdata),
    .scl_in(scl_w), .scl_out(scl_o), .scl_oe_out(scl_oe),
    .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .load_byte_out(load_byte), .load_offset_out(load_offset), .load_strobe_out(load_strobe)
  );

  esbm_slave_model #(.DEV_ADDR(ROM_ADDR)) u_slave (
    .scl_in(scl_w), .sda_in(sda_w), .sda_pull_out(slv_pull)
  );

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    @(negedge ref_clk);
    cfg_addr = a;
    cfg_wdata = dt;
    cfg_wr = 1'b1;
    @(negedge ref_clk);
    cfg_wr = 1'b0;
  endtask

  // A zero mask notes a read whose value is only polled, not judged.
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(negedge ref_clk);
    cfg_addr = a;
    cfg_rd = 1'b1;
    rq.push_back({m, e});
    @(negedge ref_clk);
    cfg_rd = 1'b0;
  endtask

  task automatic wait_idle;
    int n;
    for (n = 0; n < 25000; n++) begin
      rd(OFS_CTRL, 8'h00, 8'h00);
      if (cfg_rdata[CTL_BUSY] === 1'b0) break;
    end
    if (n == 25000) begin
      miscompares++;
      summarize();
    end
  endtask

  always @(posedge ref_clk) rd_seen <= cfg_rd;

  always @(negedge ref_clk) begin
    if (rd_seen && rq.size() > 0) begin
      e_r = rq.pop_front();
      if (e_r[15:8] != 8'h00) check("cfg_rdata", cfg_rdata & e_r[15:8], e_r[7:0]);
    end
    if (load_strobe === 1'b1) begin
      e_l = (lq.size() > 0) ? lq.pop_front() : 16'hffff;
      check("load_byte", load_byte, e_l[7:0]);
      check("load_offset", load_offset, e_l[15:8]);
    end
  end

  always @(posedge scl_w) begin
    check("scl_fast", 8'(last_rise > 0 && $realtime - last_rise < 10000.0), 8'h00);
    last_rise = $realtime;
  end

  // About 160 bit times of traffic; the limit leaves a fifth in hand.
  initial begin
    #2000000;
    miscompares++;
    summarize();
  end

  initial begin
    for (int i = 0; i < 256; i++) u_slave.mem[i] = 8'($random(seed));
    for (int i = 0; i < 4; i++) lq.push_back({8'(i), u_slave.mem[i]});
    repeat (5) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (60) @(negedge ref_clk);
    wait_idle();
    rd(OFS_CTRL, 8'h1e, 8'h10);
    check("load_left", 8'(lq.size()), 8'h00);
    d = 8'($random(seed));
    ix = 8'($random(seed));
    wr(OFS_DATA, d);
    wr(OFS_INDEX, ix);
    wr(8'hb7, 8'hff);
    rd(OFS_DATA, 8'hff, d);
    rd(OFS_INDEX, 8'hff, ix);
    rd(8'hb7, 8'hff, 8'h00);
    // The second launch lands while busy and must leave no trace.
    wr(OFS_TADDR, {ROM_ADDR, 1'b0});
    wr(OFS_TADDR, 8'h66);
    wait_idle();
    rd(OFS_TADDR, 8'hff, {ROM_ADDR, 1'b0});
    rd(OFS_CTRL, 8'h0e, 8'h00);
    check("slave_byte", u_slave.mem[ix], d);
    ix = ix + 8'h5b;
    v = u_slave.mem[ix];
    wr(OFS_INDEX, ix);
    wr(OFS_TADDR, {ROM_ADDR, 1'b1});
    wait_idle();
    rd(OFS_DATA, 8'hff, v);
    rd(OFS_CTRL, 8'h0e, 8'h08);
    // Quick command: address, acknowledge, stop; data and index stay untouched.
    wr(OFS_CTRL, 8'h01);
    wr(OFS_TADDR, {ROM_ADDR, 1'b0});
    wait_idle();
    rd(OFS_CTRL, 8'h0f, 8'h01);
    rd(OFS_DATA, 8'hff, v);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_TADDR, 8'h66);
    wait_idle();
    rd(OFS_CTRL, 8'h0e, 8'h02);
    wr(OFS_CTRL, 8'h02);
    rd(OFS_CTRL, 8'h0b, 8'h00);
    // A reset with SCL held low must find no EEPROM and start no load.
    scl_hold = 1'b1;
    reset_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (60) @(negedge ref_clk);
    rd(OFS_CTRL, 8'h1f, 8'h00);
    rd(OFS_DATA, 8'hff, 8'h00);
    // Let the watcher take the last read before the verdict.
    repeat (2) @(negedge ref_clk);
    summarize();
  end
endmodule // eeprom_serial_bus_master_tb_top
`default_nettype wire
